// ===== logic/fcsm_pkg.sv
// fcsm_pkg: command codes, status layout, reset values and state types
package fcsm_pkg;

  // ****************************************
  // command codes (low byte of a write)
  // ****************************************
  localparam logic [7:0] CMD_PROG_ALT    = 8'h10;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_PROG_SETUP  = 8'h40;
  localparam logic [7:0] CMD_CLR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_PROT_SETUP  = 8'h60;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_CFG    = 8'h90;
  localparam logic [7:0] CMD_READ_QUERY  = 8'h98;
  localparam logic [7:0] CMD_SUSPEND     = 8'hB0;
  localparam logic [7:0] CMD_CONFIRM     = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
  localparam logic [7:0] CMD_LOCK        = 8'h01;
  localparam logic [7:0] CMD_RCR_DATA    = 8'h03;
  localparam logic [7:0] CMD_LOCK_DOWN   = 8'h2F;
  localparam logic [7:0] CMD_RESERVED    = 8'h00;

  // ****************************************
  // status byte layout and reset values
  // ****************************************
  localparam int SR_READY  = 7;
  localparam int SR_ESUSP  = 6;
  localparam int SR_EFAIL  = 5;
  localparam int SR_PFAIL  = 4;
  localparam int SR_SUPPLY = 3;
  localparam int SR_PSUSP  = 2;
  localparam int SR_LOCK   = 1;
  localparam logic [15:0] RCR_RST  = 16'h0000;
  localparam logic        LOCK_RST = 1'b1;

  // ****************************************
  // identifier read offsets (low address byte)
  // ****************************************
  localparam logic [7:0] CFG_MFR_ADDR  = 8'h00;
  localparam logic [7:0] CFG_DEV_ADDR  = 8'h01;
  localparam logic [7:0] CFG_LOCK_ADDR = 8'h02;
  localparam logic [7:0] CFG_RCR_ADDR  = 8'h05;

  // ****************************************
  // strobe vector positions
  // ****************************************
  localparam int ST_CE   = 0;
  localparam int ST_ADV  = 1;
  localparam int ST_OE   = 2;
  localparam int ST_WE   = 3;
  localparam int ST_BCLK = 4;
  localparam int ST_VPP  = 5;
  localparam int NST     = 6;
  localparam logic [5:0] ST_RST = 6'h0F;

  typedef enum logic [1:0] {
    MODE_ARRAY  = 2'b00,
    MODE_STATUS = 2'b01,
    MODE_CFG    = 2'b10,
    MODE_QUERY  = 2'b11
  } fcsm_mode_t;

  typedef enum logic [1:0] {
    ARM_NONE  = 2'b00,
    ARM_ERASE = 2'b01,
    ARM_PROT  = 2'b10,
    ARM_PROG  = 2'b11
  } fcsm_arm_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_BUSY = 2'b01,
    SEQ_SUSP = 2'b10
  } fcsm_seq_t;

endpackage

// ===== logic/fcsm_if.sv
// fcsm_if: synchronised pin levels and lock table access between modules
`timescale 1ns/1ps

interface fcsm_pins_if #(parameter int W = 1);
  logic [W-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface

interface fcsm_lock_if #(parameter int BW = 6);
  logic [BW-1:0] upd_blk;
  logic          set_lock;
  logic          set_down;
  logic          clr_lock;
  logic [BW-1:0] wq_blk;
  logic          wq_locked;
  logic [BW-1:0] rq_blk;
  logic          rq_locked;
  logic          rq_down;
  modport tbl (input upd_blk, set_lock, set_down, clr_lock, wq_blk, rq_blk,
               output wq_locked, rq_locked, rq_down);
  modport ctl (output upd_blk, set_lock, set_down, clr_lock, wq_blk, rq_blk,
               input wq_locked, rq_locked, rq_down);
endinterface

// ===== logic/fcsm_pin_sync.sv
// fcsm_pin_sync: two-stage synchroniser for a group of pins
`timescale 1ns/1ps

module fcsm_pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] raw,
  fcsm_pins_if.src          p
);
  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      meta  <= RST;
      p.lvl <= RST;
    end else begin
      meta  <= raw;
      p.lvl <= meta;
    end
  end
endmodule

// ===== logic/fcsm_lock_table.sv
// fcsm_lock_table: per-block lock and lock-down bits
`timescale 1ns/1ps

module fcsm_lock_table #(
  parameter int NBLK = 64,
  parameter int BW   = 6
) (
  input  wire logic sys_clk,
  input  wire logic rstn,
  fcsm_lock_if.tbl  lk
);
  logic [NBLK-1:0] locked;
  logic [NBLK-1:0] down;

  // lock-down is left only by reset; blocks come up locked
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      locked <= {NBLK{fcsm_pkg::LOCK_RST}};
      down   <= '0;
    end else begin
      if (lk.set_lock || lk.set_down)
        locked[lk.upd_blk] <= 1'b1;
      else if (lk.clr_lock && !down[lk.upd_blk])
        locked[lk.upd_blk] <= 1'b0;
      if (lk.set_down)
        down[lk.upd_blk] <= 1'b1;
    end
  end

  assign lk.wq_locked = locked[lk.wq_blk];
  assign lk.rq_locked = locked[lk.rq_blk];
  assign lk.rq_down   = down[lk.rq_blk];

  AST_LOCK_SETS: assert property (@(posedge sys_clk) disable iff (!rstn)
    lk.set_lock |=> locked[$past(lk.upd_blk)])
    else $error("lock command did not lock block");
  AST_DOWN_SETS: assert property (@(posedge sys_clk) disable iff (!rstn)
    lk.set_down |=> down[$past(lk.upd_blk)] && locked[$past(lk.upd_blk)])
    else $error("lock-down command did not take");
  AST_DOWN_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
    lk.clr_lock && down[lk.upd_blk] |=> locked[$past(lk.upd_blk)])
    else $error("unlock freed a locked-down block");
endmodule

// ===== logic/fcsm_top.sv
// fcsm_top: dual-bank flash command decoder, mode control and status
// Operation
// - erase confirm after setup starts block erase
// - busy: only status and suspend accepted
// - after start, bank reads status register
// - resume restarts the suspended operation
// - read-array code selects array data output
// - lock code after protection setup locks block
// - configuration code stores address bits
// - lock-down code after setup locks block down
// - unlock frees block unless locked down
// - completion sets ready, full command set
// - command state held until next write
// - no start without valid programming supply
// - error flags sticky; clear-status clears them only when idle
// - reset leaves banks in array read
// - identifier mode returns id, lock, configuration
// - query code selects query data output
// - address latched, data refreshed on strobes
// - erase setup then other code: status, ignore
// - protection setup then other code: status
// - suspend halts, sets suspend and ready
`timescale 1ns/1ps

module fcsm_top #(
  parameter int          AW         = 21,
  parameter int          BW         = 6,
  parameter int          NBLK       = 64,
  parameter logic [5:0]  BANK_B_BLK = 6'h08,
  parameter logic [15:0] MFR_ID     = 16'h00A5, // arbitrary value
  parameter logic [15:0] DEV_ID     = 16'h005A  // arbitrary value
) (
  input  wire logic          sys_clk,
  input  wire logic          rstn,
  input  wire logic          chip_sel_n,
  input  wire logic          address_latch_strobe_n,
  input  wire logic          out_en_n,
  input  wire logic          write_en_n,
  input  wire logic          burst_clk,
  input  wire logic          supply_in_range,
  input  wire logic [AW-1:0] addr,
  input  wire logic [15:0]   data_lines_in,
  output logic      [15:0]   data_lines_out,
  output logic               data_lines_oe,
  output logic      [AW-1:0] array_addr,
  input  wire logic [15:0]   array_rdata,
  input  wire logic [15:0]   query_rdata,
  output logic               op_start,
  output logic               op_erase,
  output logic      [AW-1:0] op_addr,
  output logic      [15:0]   op_data,
  output logic               op_suspend,
  output logic               op_resume,
  input  wire logic          op_done,
  input  wire logic          op_fail,
  output logic      [15:0]   read_config
);

  // ****************************************
  // pin synchronisers and edge detection
  // ****************************************
  fcsm_pins_if #(.W(fcsm_pkg::NST)) st_if ();
  fcsm_pins_if #(.W(AW + 16)) bus_if ();
  fcsm_lock_if #(.BW(BW)) lk ();

  fcsm_pin_sync #(.W(fcsm_pkg::NST), .RST(fcsm_pkg::ST_RST)) u_st_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     ({supply_in_range, burst_clk, write_en_n, out_en_n,
               address_latch_strobe_n, chip_sel_n}),
    .p       (st_if.src)
  );

  fcsm_pin_sync #(.W(AW + 16)) u_bus_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .raw     ({addr, data_lines_in}),
    .p       (bus_if.src)
  );

  fcsm_lock_table #(.NBLK(NBLK), .BW(BW)) u_locks (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .lk      (lk.tbl)
  );

  function automatic logic [BW-1:0] blk_of(input logic [AW-1:0] a);
    return a[AW-1 -: BW];
  endfunction

  function automatic logic bank_of(input logic [AW-1:0] a);
    return blk_of(a) >= BANK_B_BLK;
  endfunction

  logic [fcsm_pkg::NST-1:0] st;
  logic [fcsm_pkg::NST-1:0] st_d;
  logic [AW-1:0]            s_addr;
  logic [15:0]              s_data;
  logic [7:0]               cmd;

  assign st     = st_if.lvl;
  assign s_addr = bus_if.lvl[AW+15:16];
  assign s_data = bus_if.lvl[15:0];
  assign cmd    = s_data[7:0];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      st_d <= fcsm_pkg::ST_RST;
    else
      st_d <= st;
  end

  logic ce_lo;
  logic oe_lo;
  logic adv_lo;
  logic vpp_ok;
  logic wr_take;
  logic rd_upd;
  logic rd_upd_q;

  assign ce_lo   = !st[fcsm_pkg::ST_CE];
  assign oe_lo   = !st[fcsm_pkg::ST_OE];
  assign adv_lo  = !st[fcsm_pkg::ST_ADV];
  assign vpp_ok  = st[fcsm_pkg::ST_VPP];
  assign wr_take = st[fcsm_pkg::ST_WE] && !st_d[fcsm_pkg::ST_WE] && ce_lo;
  // data refresh: strobe fall, burst clock while strobe low, later of oe/ce
  assign rd_upd  = (adv_lo && st_d[fcsm_pkg::ST_ADV])
                 || (adv_lo && st[fcsm_pkg::ST_BCLK] && !st_d[fcsm_pkg::ST_BCLK])
                 || (ce_lo && oe_lo && (st_d[fcsm_pkg::ST_OE] || st_d[fcsm_pkg::ST_CE]));

  // ****************************************
  // per-bank command state
  // ****************************************
  fcsm_pkg::fcsm_mode_t mode [2];
  fcsm_pkg::fcsm_mode_t next_mode [2];
  fcsm_pkg::fcsm_arm_t  arm [2];
  fcsm_pkg::fcsm_arm_t  next_arm [2];
  fcsm_pkg::fcsm_seq_t  seq;
  logic                 op_bank;
  logic                 wb;
  logic                 idle;
  logic                 try_erase;
  logic                 try_prog;
  logic                 do_lock;
  logic                 do_down;
  logic                 do_unlock;
  logic                 do_rcr;
  logic                 do_clr;
  logic                 do_susp;
  logic                 do_resume;

  assign wb   = bank_of(s_addr);
  assign idle = seq == fcsm_pkg::SEQ_IDLE;

  always_comb begin
    next_mode = mode;
    next_arm  = arm;
    try_erase = 1'b0;
    try_prog  = 1'b0;
    do_lock   = 1'b0;
    do_down   = 1'b0;
    do_unlock = 1'b0;
    do_rcr    = 1'b0;
    do_clr    = 1'b0;
    do_susp   = 1'b0;
    do_resume = 1'b0;
    if (wr_take) begin
      if (seq == fcsm_pkg::SEQ_BUSY) begin
        if (cmd == fcsm_pkg::CMD_READ_STATUS)
          next_mode[wb] = fcsm_pkg::MODE_STATUS;
        else if (cmd == fcsm_pkg::CMD_SUSPEND && wb == op_bank)
          do_susp = 1'b1;
      end else begin
        next_arm[wb] = fcsm_pkg::ARM_NONE;
        unique case (arm[wb])
          fcsm_pkg::ARM_ERASE: begin
            if (cmd == fcsm_pkg::CMD_CONFIRM)
              try_erase = 1'b1;
            next_mode[wb] = fcsm_pkg::MODE_STATUS;
          end
          fcsm_pkg::ARM_PROT: begin
            if (cmd == fcsm_pkg::CMD_LOCK)
              do_lock = 1'b1;
            else if (cmd == fcsm_pkg::CMD_LOCK_DOWN)
              do_down = 1'b1;
            else if (cmd == fcsm_pkg::CMD_CONFIRM)
              do_unlock = 1'b1;
            else if (cmd == fcsm_pkg::CMD_RCR_DATA)
              do_rcr = 1'b1;
            else
              next_mode[wb] = fcsm_pkg::MODE_STATUS;
          end
          fcsm_pkg::ARM_PROG: begin
            try_prog      = 1'b1;
            next_mode[wb] = fcsm_pkg::MODE_STATUS;
          end
          fcsm_pkg::ARM_NONE: begin
            case (cmd)
              fcsm_pkg::CMD_READ_ARRAY:  next_mode[wb] = fcsm_pkg::MODE_ARRAY;
              fcsm_pkg::CMD_READ_STATUS: next_mode[wb] = fcsm_pkg::MODE_STATUS;
              fcsm_pkg::CMD_READ_CFG:    next_mode[wb] = fcsm_pkg::MODE_CFG;
              fcsm_pkg::CMD_READ_QUERY:  next_mode[wb] = fcsm_pkg::MODE_QUERY;
              fcsm_pkg::CMD_CLR_STATUS: begin
                if (idle) begin
                  do_clr        = 1'b1;
                  next_mode[wb] = fcsm_pkg::MODE_ARRAY;
                end
              end
              fcsm_pkg::CMD_ERASE_SETUP: begin
                if (idle)
                  next_arm[wb] = fcsm_pkg::ARM_ERASE;
              end
              fcsm_pkg::CMD_PROT_SETUP: begin
                if (idle)
                  next_arm[wb] = fcsm_pkg::ARM_PROT;
              end
              fcsm_pkg::CMD_PROG_SETUP, fcsm_pkg::CMD_PROG_ALT: begin
                if (idle)
                  next_arm[wb] = fcsm_pkg::ARM_PROG;
              end
              fcsm_pkg::CMD_CONFIRM: begin
                if (seq == fcsm_pkg::SEQ_SUSP)
                  do_resume = 1'b1;
              end
              // reserved and unknown codes change nothing
              default: ;
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode <= '{fcsm_pkg::MODE_ARRAY, fcsm_pkg::MODE_ARRAY};
      arm  <= '{fcsm_pkg::ARM_NONE, fcsm_pkg::ARM_NONE};
    end else begin
      mode <= next_mode;
      arm  <= next_arm;
    end
  end

  // ****************************************
  // embedded operation sequencer handshake
  // ****************************************
  logic try_op;
  logic start_ok;

  assign try_op   = try_erase || try_prog;
  assign start_ok = try_op && !lk.wq_locked && vpp_ok;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      seq        <= fcsm_pkg::SEQ_IDLE;
      op_bank    <= 1'b0;
      op_erase   <= 1'b0;
      op_addr    <= '0;
      op_data    <= '0;
      op_start   <= 1'b0;
      op_suspend <= 1'b0;
      op_resume  <= 1'b0;
    end else begin
      op_start   <= start_ok;
      op_suspend <= do_susp && !op_done;
      op_resume  <= do_resume;
      unique case (seq)
        fcsm_pkg::SEQ_IDLE: begin
          if (start_ok) begin
            seq      <= fcsm_pkg::SEQ_BUSY;
            op_bank  <= wb;
            op_erase <= try_erase;
            op_addr  <= s_addr;
            op_data  <= s_data;
          end
        end
        fcsm_pkg::SEQ_BUSY: begin
          if (op_done)
            seq <= fcsm_pkg::SEQ_IDLE;
          else if (do_susp)
            seq <= fcsm_pkg::SEQ_SUSP;
        end
        fcsm_pkg::SEQ_SUSP: begin
          if (do_resume)
            seq <= fcsm_pkg::SEQ_BUSY;
        end
        default: seq <= fcsm_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ****************************************
  // status flags and configuration register
  // ****************************************
  logic       f_lock;
  logic       f_supply;
  logic       f_pfail;
  logic       f_efail;
  logic       done_fail;
  logic [7:0] status;

  assign done_fail = seq == fcsm_pkg::SEQ_BUSY && op_done && op_fail;

  // a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      f_lock      <= 1'b0;
      f_supply    <= 1'b0;
      f_pfail     <= 1'b0;
      f_efail     <= 1'b0;
      read_config <= fcsm_pkg::RCR_RST;
    end else begin
      f_lock   <= (try_op && lk.wq_locked) || (f_lock && !do_clr);
      f_supply <= (try_op && !lk.wq_locked && !vpp_ok) || (f_supply && !do_clr);
      f_pfail  <= (done_fail && !op_erase) || (f_pfail && !do_clr);
      f_efail  <= (done_fail && op_erase) || (f_efail && !do_clr);
      if (do_rcr)
        read_config <= s_addr[15:0];
    end
  end

  // ready and suspend bits follow the sequencer state directly
  assign status = {seq != fcsm_pkg::SEQ_BUSY,
                   seq == fcsm_pkg::SEQ_SUSP && op_erase,
                   f_efail, f_pfail, f_supply,
                   seq == fcsm_pkg::SEQ_SUSP && !op_erase,
                   f_lock, 1'b0};

  assign lk.upd_blk  = blk_of(s_addr);
  assign lk.wq_blk   = blk_of(s_addr);
  assign lk.set_lock = do_lock;
  assign lk.set_down = do_down;
  assign lk.clr_lock = do_unlock;

  // ****************************************
  // read path
  // ****************************************
  logic        rb;
  logic [15:0] cfg_val;
  logic [15:0] rd_val;

  // transparent while the strobe is low, held from its rising edge
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      array_addr <= '0;
    else if (adv_lo)
      array_addr <= s_addr;
  end

  assign rb        = bank_of(array_addr);
  assign lk.rq_blk = blk_of(array_addr);
  assign cfg_val   = array_addr[7:0] == fcsm_pkg::CFG_MFR_ADDR  ? MFR_ID
                   : array_addr[7:0] == fcsm_pkg::CFG_DEV_ADDR  ? DEV_ID
                   : array_addr[7:0] == fcsm_pkg::CFG_LOCK_ADDR ?
                       {14'h0000, lk.rq_down, lk.rq_locked}
                   : array_addr[7:0] == fcsm_pkg::CFG_RCR_ADDR  ? read_config
                   : 16'h0000;
  assign rd_val    = mode[rb] == fcsm_pkg::MODE_ARRAY  ? array_rdata
                   : mode[rb] == fcsm_pkg::MODE_STATUS ? {8'h00, status}
                   : mode[rb] == fcsm_pkg::MODE_CFG    ? cfg_val
                   : query_rdata;

  // the array sees the new read address one cycle after the strobe falls,
  // so the refresh waits that cycle instead of loading a stale word
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_upd_q       <= 1'b0;
      data_lines_out <= '0;
    end else begin
      rd_upd_q <= rd_upd;
      if (rd_upd_q)
        data_lines_out <= rd_val;
    end
  end

  assign data_lines_oe = ce_lo && oe_lo && st[fcsm_pkg::ST_WE];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_ERASE_START: assert property (
    idle && try_erase && !lk.wq_locked && vpp_ok |=> op_start && op_erase
      && seq == fcsm_pkg::SEQ_BUSY)
    else $error("erase confirm did not start erase");
  AST_BUSY_IGNORE: assert property (
    seq == fcsm_pkg::SEQ_BUSY && wr_take && cmd != fcsm_pkg::CMD_READ_STATUS
      |=> mode[0] == $past(mode[0]) && mode[1] == $past(mode[1]) && !op_start)
    else $error("command accepted while busy");
  AST_START_STATUS: assert property (
    op_start |-> mode[op_bank] == fcsm_pkg::MODE_STATUS && !status[fcsm_pkg::SR_READY])
    else $error("bank not in status read after start");
  AST_RESUME: assert property (
    do_resume |=> op_resume && seq == fcsm_pkg::SEQ_BUSY)
    else $error("resume did not restart operation");
  AST_ARRAY_MODE: assert property (
    wr_take && idle && arm[wb] == fcsm_pkg::ARM_NONE && cmd == fcsm_pkg::CMD_READ_ARRAY
      |=> mode[$past(wb)] == fcsm_pkg::MODE_ARRAY)
    else $error("read array code ignored");
  AST_RCR_LOAD: assert property (
    do_rcr |=> read_config == $past(s_addr[15:0]))
    else $error("configuration register not loaded");
  AST_DONE_READY: assert property (
    seq == fcsm_pkg::SEQ_BUSY && op_done |=> status[fcsm_pkg::SR_READY] && idle)
    else $error("ready not set on completion");
  AST_NO_SUPPLY: assert property (
    try_op && !vpp_ok |=> !op_start ##0 (f_supply || f_lock))
    else $error("operation started without supply");
  AST_CLEAR: assert property (
    do_clr && !try_op && !done_fail |=> status[5:1] == 5'h00)
    else $error("clear status left flags set");
  AST_SUSPEND: assert property (
    do_susp && !op_done |=> op_suspend && status[fcsm_pkg::SR_READY]
      && (status[fcsm_pkg::SR_ESUSP] || status[fcsm_pkg::SR_PSUSP]))
    else $error("suspend not reported");
  AST_READ_UPDATE: assert property (
    rd_upd_q |=> data_lines_out == $past(rd_val))
    else $error("read data not refreshed");
endmodule

// ===== tb/fcsm_seq_model.sv
// fcsm_seq_model: embedded operation sequencer and memory contents seen by the block
`timescale 1ns/1ps
module fcsm_seq_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        op_start,
  input  wire logic        op_suspend,
  input  wire logic        op_resume,
  input  wire logic        fail_next,
  input  wire logic [7:0]  lat,
  input  wire logic [20:0] array_addr,
  output logic             op_done,
  output logic             op_fail,
  output logic      [15:0] array_rdata,
  output logic      [15:0] query_rdata
);
  logic [7:0] cnt;
  logic       held;
  // address-derived words so that a stale read address shows up in the data
  assign array_rdata = array_addr[15:0] ^ 16'h5A5A;
  assign query_rdata = ~array_addr[15:0];
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
      held <= 1'b0;
      op_done <= 1'b0;
    end else begin
      if (op_start) cnt <= lat;
      else if (cnt != 0 && !held) cnt <= cnt - 8'h01;
      if (op_suspend) held <= 1'b1;
      else if (op_resume) held <= 1'b0;
      op_done <= cnt == 8'h01 && !held && !op_suspend;
    end
  end
  // the fail level is not qualified by done: the block must sample it only then
  assign op_fail = fail_next;
endmodule

// ===== tb/fcsm_top_tb_top.sv
// fcsm_top_tb_top: command, mode and status checks against a bench model
`timescale 1ns/1ps
module fcsm_top_tb_top;
  logic        sys_clk, rstn, ce_n, adv_n, oe_n, we_n, burst_clk, vpp_ok, oe, fail_next;
  logic        op_start, op_erase, op_suspend, op_resume, op_done, op_fail;
  logic [20:0] addr, array_addr, op_addr, a;
  logic [15:0] din, dout, array_rdata, query_rdata, op_data, read_config;
  logic [7:0]  lat;
  logic [11:0] prot [5] = '{12'h4D0, 12'h401, 12'h52F, 12'h5D0, 12'h6D0};
  int          n_fail, check_count, seed, n_start, n_sus, n_res;
  fcsm_top fcsm_top_inst (.sys_clk(sys_clk), .rstn(rstn), .chip_sel_n(ce_n),
    .address_latch_strobe_n(adv_n), .out_en_n(oe_n), .write_en_n(we_n), .burst_clk(burst_clk),
    .supply_in_range(vpp_ok), .addr(addr), .data_lines_in(din), .data_lines_out(dout),
    .data_lines_oe(oe), .array_addr(array_addr), .array_rdata(array_rdata),
    .query_rdata(query_rdata), .op_start(op_start), .op_erase(op_erase), .op_addr(op_addr),
    .op_data(op_data), .op_suspend(op_suspend), .op_resume(op_resume), .op_done(op_done),
    .op_fail(op_fail), .read_config(read_config));
  fcsm_seq_model fcsm_seq_model_inst (.sys_clk(sys_clk), .rstn(rstn), .op_start(op_start),
    .op_suspend(op_suspend), .op_resume(op_resume), .fail_next(fail_next), .lat(lat),
    .array_addr(array_addr), .op_done(op_done), .op_fail(op_fail),
    .array_rdata(array_rdata), .query_rdata(query_rdata));
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    burst_clk = 0;
    forever #40 burst_clk = ~burst_clk;
  end
  always @(posedge op_start) n_start++;
  always @(posedge op_suspend) n_sus++;
  always @(posedge op_resume) n_res++;
  function automatic logic [20:0] ba(input int b, input int o);
    return {b[5:0], o[14:0]};
  endfunction
  function automatic logic [15:0] ar(input logic [20:0] x);
    return x[15:0] ^ 16'h5A5A;
  endfunction
  task automatic give_verdict;
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // ********************************
  // host cycles, held well past the two sync flops
  // ********************************
  task automatic wr(input logic [20:0] wa, input logic [7:0] c);
    chk("reserved code", c == 8'h00, 0);
    addr = wa;
    din = {8'hC3, c};
    {ce_n, we_n} = 2'b00;
    repeat (4) @(negedge sys_clk);
    we_n = 1;
    repeat (4) @(negedge sys_clk);
    ce_n = 1;
    din = ~din;
    @(negedge sys_clk);
  endtask
  task automatic rdc(input logic [20:0] ra, input logic [15:0] exp, input string what);
    addr = ra;
    @(negedge sys_clk);
    {ce_n, adv_n, oe_n} = 3'b000;
    repeat (6) @(negedge sys_clk);
    chk("oe", oe, 1);
    chk(what, dout, exp);
    {ce_n, adv_n, oe_n} = 3'b111;
    addr = ~addr;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic wait_op(input int n);
    for (int i = 0; i < 40 && n_start < n; i++) @(negedge sys_clk);
    chk("started", n_start, n);
  endtask
  initial begin
    seed = 75372;
    {rstn, ce_n, adv_n, oe_n, we_n, vpp_ok, fail_next} = 7'b0111110;
    {addr, din, lat} = '0;
    repeat (12) @(negedge sys_clk);
    rstn = 1;
    repeat (3) @(negedge sys_clk);
    rdc(ba(9, 5), ar(ba(9, 5)), "reset mode");
    wr(ba(3, 0), 8'h70);
    rdc(ba(3, 0), 16'h0080, "status");
    wr(ba(3, 0), 8'h20);
    wr(ba(3, 0), 8'hD0);
    rdc(ba(3, 0), 16'h0082, "locked");
    wr(ba(3, 0), 8'h50);
    rdc(ba(3, 1), ar(ba(3, 1)), "cleared");
    wr(ba(3, 0), 8'h60);
    wr(ba(3, 0), 8'hD0);
    vpp_ok = 0;
    wr(ba(3, 0), 8'h20);
    wr(ba(3, 0), 8'hD0);
    rdc(ba(3, 0), 16'h0088, "supply");
    chk("no start", n_start, 0);
    vpp_ok = 1;
    wr(ba(3, 0), 8'h50);
    {fail_next, lat} = {1'b1, 8'd60};
    wr(ba(3, 0), 8'h20);
    wr(ba(3, 7), 8'hD0);
    wait_op(1);
    chk("erase", {op_erase, op_addr}, {1'b1, ba(3, 7)});
    chk("erase data", op_data, 16'hC3D0);
    rdc(ba(3, 0), 16'h0000, "busy");
    rdc(ba(9, 2), ar(ba(9, 2)), "other bank");
    wr(ba(3, 0), 8'h90);
    rdc(ba(3, 0), 16'h0000, "ignored");
    repeat (40) @(negedge sys_clk);
    rdc(ba(3, 0), 16'h00A0, "done");
    wr(ba(3, 0), 8'h50);
    rdc(ba(3, 0), ar(ba(3, 0)), "clear");
    for (int k = 0; k < 2; k++) begin
      wr(ba(3, 0), k ? 8'h60 : 8'h20);
      wr(ba(3, 0), 8'h98);
      rdc(ba(3, 0), 16'h0080, "abort");
    end
    foreach (prot[i]) begin
      wr(ba(prot[i][11:8], 0), 8'h60);
      wr(ba(prot[i][11:8], 0), prot[i][7:0]);
    end
    wr(0, 8'h90);
    rdc(ba(4, 2), 16'h0001, "lock");
    rdc(ba(5, 2), 16'h0003, "down");
    rdc(ba(6, 2), 16'h0000, "unlock");
    wr(0, 8'hFF);
    wr(0, 8'h98);
    rdc(ba(2, 16), 16'hFFEF, "query");
    wr(0, 8'hFF);
    rdc(ba(2, 16), ar(ba(2, 16)), "array");
    a = 21'($random(seed));
    wr(a, 8'h60);
    wr(a, 8'h03);
    chk("config", read_config, a[15:0]);
    {fail_next, lat} = {1'b0, 8'd200};
    wr(ba(3, 0), 8'h20);
    wr(ba(3, 0), 8'hD0);
    wait_op(2);
    wr(ba(3, 0), 8'hB0);
    rdc(ba(3, 0), 16'h00C0, "suspend");
    wr(ba(3, 0), 8'hD0);
    chk("pulses", n_sus + 2 * n_res, 3);
    rdc(ba(3, 0), 16'h0000, "resumed");
    repeat (220) @(negedge sys_clk);
    rdc(ba(3, 0), 16'h0080, "ready");
    // alternate program setup, failing, exercises the program error flag
    {fail_next, lat} = {1'b1, 8'd20};
    wr(ba(3, 0), 8'h10);
    wr(ba(3, 3), 8'h5C);
    wait_op(3);
    chk("program", {op_erase, op_addr}, {1'b0, ba(3, 3)});
    chk("program data", op_data, 16'hC35C);
    repeat (40) @(negedge sys_clk);
    rdc(ba(3, 0), 16'h0090, "program fail");
    give_verdict();
  end
endmodule
